// [include/ir_rx_regs.svh]
`ifndef IR_RX_REGS_SVH
`define IR_RX_REGS_SVH

// System clock and sampling timer base
`define IR_CLK_HZ 10000000
`define IR_TICK_NS 1000
`define IR_HALF_BIT_US 889

// Frame layout, bit 13 is the first bit on the air
`define IR_FRAME_BITS 14
`define IR_START1_POS 13
`define IR_START2_POS 12
`define IR_TOGGLE_POS 11
`define IR_ADDR_MSB 10
`define IR_ADDR_LSB 6
`define IR_CMD_MSB 5
`define IR_CMD_LSB 0
`define IR_ADDR_W 5
`define IR_CMD_W 8

// Placement inside the command output byte
`define IR_EXT_OUT_POS 6
`define IR_TOG_OUT_POS 7

// Decoded word buffer
`define IR_FIFO_DEPTH 16

`endif

// [include/ir_rx_pkg.sv]
package ir_rx_pkg;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_MID     = 5'h02,
    ST_BETWEEN = 5'h04,
    ST_PUSH    = 5'h08,
    ST_GAP     = 5'h10
  } ir_state_t;

endpackage

// [design/ir_fifo.sv]
module ir_fifo import ir_rx_pkg::*; #(
  parameter int W = 13,
  parameter int DEPTH = 16
) (
  input wire logic clk_in, // System clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic in_valid_in, // Write request
  output logic in_ready_out, // Not full
  input wire logic [W-1:0] in_data_in, // Write data
  output logic out_valid_out, // Not empty
  input wire logic out_ready_in, // Read accept
  output logic [W-1:0] out_data_out // Head word
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_t;

  fifo_t s_q, s_d;
  logic push, pop;

  assign in_ready_out = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = (s_q.cnt != '0);
  assign out_data_out = s_q.mem[s_q.rd];

  always_comb begin
    s_d = s_q;
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    if (push) begin
      s_d.mem[s_q.wr] = in_data_in;
      s_d.wr = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // ir_fifo

// [design/biphase_ir_remote_receiver.sv]
// Summary of operation
// [R1] A frame is one 14-bit code word, presented only once all bits are in.
// [R2] The first two bits are start bits of value 1 and mark the frame start.
// [R3] The third bit is the toggle bit, flipped on every new key press.
// [R4] The five bits after the toggle bit form the system address output.
// [R5] The last six bits form the command, up to 64 commands per address.
// [R6] Each bit is bi-phase coded and read at its mid-bit transition.
// [R7] Extended codes are accepted, with the extended bit in command bit 6.
// [R8] The toggle bit sits in bit 7 of the command byte.
// [R9] The input is chosen from any input pin by a pin select setting.
// [R10] Half-bits are 889 us; a quarter-bit edge error rejects the frame.
// [R11] Address and command update together with a one-cycle valid pulse.
`include "ir_rx_regs.svh"

module biphase_ir_remote_receiver import ir_rx_pkg::*; #(
  parameter int PIN_CNT = 8,
  parameter int HALF_BIT_US = `IR_HALF_BIT_US,
  parameter bit ACTIVE_LOW = 1'b1
) (
  input wire logic MCLK_IN, // 10 MHz system clock
  input wire logic RST_N_IN, // Async reset, active low
  input wire logic [PIN_CNT-1:0] IR_PINS_IN, // Candidate input pins
  input wire logic [$clog2(PIN_CNT)-1:0] IR_INPUT_PIN_SELECT_IN, // Pin
  input wire logic EXT_EN_IN, // Accept extended codes
  input wire logic READY_IN, // Consumer takes a code
  output logic [`IR_ADDR_W-1:0] ADDR_OUT, // System address
  output logic [`IR_CMD_W-1:0] CMD_OUT, // Toggle, ext, command
  output logic VALID_OUT, // One-cycle new code pulse
  output logic ERR_OUT, // One-cycle rejected frame pulse
  output logic BUSY_OUT // Frame in progress
);

  // Sampling timer: one tick per IR_TICK_NS
  // A fixed tick keeps the gap counter narrow whatever the clock rate
  localparam int TICK_CYC = (`IR_CLK_HZ / 1000000) * `IR_TICK_NS / 1000;
  localparam int HALF_TICKS = HALF_BIT_US * 1000 / `IR_TICK_NS;
  // Twelve bits hold two and a half half-bits of ticks with room to spare
  localparam int CW = 12;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
  // Quarter bit tolerance is half of a half-bit
  localparam logic [CW-1:0] SHORT_MIN = CW'(HALF_TICKS / 2);
  localparam logic [CW-1:0] SHORT_MAX = CW'(HALF_TICKS * 3 / 2);
  localparam logic [CW-1:0] LONG_MAX = CW'(HALF_TICKS * 5 / 2);
  localparam logic [3:0] LAST_BIT = 4'(`IR_FRAME_BITS - 1);
  localparam int DW = `IR_ADDR_W + `IR_CMD_W;

  typedef struct packed {
    ir_state_t state;
    logic [7:0] presc;
    logic [CW-1:0] gap;
    logic line;
    logic [`IR_FRAME_BITS-1:0] bits;
    logic [3:0] nbits;
    logic [`IR_ADDR_W-1:0] addr;
    logic [`IR_CMD_W-1:0] cmd;
    logic valid;
    logic err;
  } rx_t;

  rx_t s_q, s_d;
  logic line_now;
  logic tick;
  logic edge_seen;
  logic rec;
  logic fail;
  logic [`IR_FRAME_BITS-1:0] nb;
  logic [`IR_CMD_W-1:0] cmd_byte;
  logic [DW-1:0] push_data;
  logic push_ready;
  logic ir_code_fetch;
  logic fifo_valid;
  logic [DW-1:0] fifo_data;

  // Demodulators usually pull low while carrier is present
  assign line_now = IR_PINS_IN[IR_INPUT_PIN_SELECT_IN] ^ ACTIVE_LOW; // R9

  assign edge_seen = (line_now != s_q.line);
  assign nb = {s_q.bits[`IR_FRAME_BITS-2:0], line_now};

  // Command byte: toggle on top, then extended bit, then six command bits
  always_comb begin
    cmd_byte = '0;
    cmd_byte[`IR_CMD_MSB:`IR_CMD_LSB] =
      s_q.bits[`IR_CMD_MSB:`IR_CMD_LSB]; // R5
    cmd_byte[`IR_EXT_OUT_POS] = ~s_q.bits[`IR_START2_POS]; // R7
    cmd_byte[`IR_TOG_OUT_POS] = s_q.bits[`IR_TOGGLE_POS]; // R3 R8
  end

  assign push_data = {s_q.bits[`IR_ADDR_MSB:`IR_ADDR_LSB], cmd_byte}; // R4

  always_comb begin
    s_d = s_q;
    s_d.valid = 1'b0;
    s_d.err = 1'b0;
    tick = 1'b0;
    rec = 1'b0;
    fail = 1'b0;
    if (s_q.presc == TICK_LAST) begin
      s_d.presc = '0;
      tick = 1'b1;
    end else begin
      s_d.presc = s_q.presc + 1'b1;
    end
    s_d.line = line_now;
    // Ticks since the last edge, saturating so long idle never wraps
    if (edge_seen) begin
      s_d.gap = '0;
    end else if (tick && s_q.gap != '1) begin
      s_d.gap = s_q.gap + 1'b1;
    end
    unique case (s_q.state)
      ST_IDLE: begin
        // First active edge is the mid-bit of the first start bit
        if (edge_seen && line_now) begin // R2
          s_d.state = ST_MID;
          s_d.bits = `IR_FRAME_BITS'(1);
          s_d.nbits = 4'h1;
        end
      end
      ST_MID: begin
        // A long gap from a mid-bit edge means the bit value flipped
        if (edge_seen) begin
          if (s_q.gap < SHORT_MIN) begin // R10
            fail = 1'b1;
          end else if (s_q.gap < SHORT_MAX) begin
            s_d.state = ST_BETWEEN; // R6
          end else if (s_q.gap <= LONG_MAX) begin
            rec = 1'b1; // R6
          end else begin
            fail = 1'b1; // R10
          end
        end else if (s_q.gap > LONG_MAX) begin
          fail = 1'b1; // R10
        end
      end
      ST_BETWEEN: begin
        // Boundary edge seen; the next edge must be a mid-bit edge
        if (edge_seen) begin
          if (s_q.gap >= SHORT_MIN && s_q.gap < SHORT_MAX) begin
            rec = 1'b1; // R6
          end else begin
            fail = 1'b1; // R10
          end
        end else if (s_q.gap > SHORT_MAX) begin
          fail = 1'b1; // R10
        end
      end
      ST_PUSH: begin
        // Decoder stalls here while the buffer is full; edges meanwhile
        // are lost, and the frame is resynchronised on the next quiet gap
        if (push_ready) begin
          s_d.state = ST_GAP;
        end
      end
      ST_GAP: begin
        // Re-arm only after a long quiet line, so the tail of a cut or
        // refused frame is never taken for a new start bit
        if (!line_now && s_q.gap > LONG_MAX) begin
          s_d.state = ST_IDLE;
        end
      end
      default: begin
        s_d.state = ST_GAP;
      end
    endcase
    if (rec) begin
      // Bit value is the level after the mid-bit transition
      s_d.bits = nb; // R6
      s_d.nbits = s_q.nbits + 1'b1;
      s_d.state = ST_MID;
      if (s_q.nbits == LAST_BIT) begin // R1
        if (nb[`IR_START1_POS] && (nb[`IR_START2_POS] || EXT_EN_IN)) begin
          s_d.state = ST_PUSH; // R2 R7
        end else begin
          fail = 1'b1; // R2
        end
      end
    end
    if (fail) begin
      s_d.state = ST_GAP;
      s_d.err = 1'b1;
    end
    // Address and command change only when a buffered code is fetched
    if (ir_code_fetch) begin
      s_d.addr = fifo_data[DW-1:`IR_CMD_W]; // R11
      s_d.cmd = fifo_data[`IR_CMD_W-1:0]; // R11
      s_d.valid = 1'b1; // R11
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s_q <= '0;
      s_q.state <= ST_GAP;
    end else begin
      s_q <= s_d;
    end
  end

  // The buffer lets the consumer lag sixteen codes behind the air; past
  // that the decoder holds in PUSH and later frames are lost
  assign ir_code_fetch = fifo_valid && READY_IN;

  ir_fifo #(
    .W(DW),
    .DEPTH(`IR_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(MCLK_IN),
    .rst_n_in(RST_N_IN),
    .in_valid_in(s_q.state == ST_PUSH),
    .in_ready_out(push_ready),
    .in_data_in(push_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(READY_IN),
    .out_data_out(fifo_data)
  );

  assign ADDR_OUT = s_q.addr;
  assign CMD_OUT = s_q.cmd;
  assign VALID_OUT = s_q.valid;
  assign ERR_OUT = s_q.err;
  assign BUSY_OUT = (s_q.state == ST_MID) || (s_q.state == ST_BETWEEN);

endmodule // biphase_ir_remote_receiver

// [tb/ir_sender.sv]
module ir_sender (
  input wire logic clk_in, // Clock
  input wire logic go_in, // Start a frame
  input wire logic [13:0] word_in, // Frame, bit 13 first
  input wire logic [31:0] half_in, // Half-bit length in clocks
  output logic line_out, // Demodulator output
  output logic busy_out // Frame on the air
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    line_out = 1'b1;
    busy_out = 1'b0;
  end
  // Active low; a bit's value is the level after its mid-bit edge
  always @(posedge clk_in) begin
    if (go_in && !busy_out) begin
      busy_out <= 1'b1;
      for (int i = 13; i >= 0; i--) begin
        line_out <= word_in[i];
        repeat (half_in) @(posedge clk_in);
        line_out <= ~word_in[i];
        repeat (half_in) @(posedge clk_in);
      end
      line_out <= 1'b1;
      busy_out <= 1'b0;
    end
  end
endmodule // ir_sender

// [tb/ir_rx_chk_sva.sv]
module ir_rx_chk import ir_rx_pkg::*; #(
  parameter int PIN_CNT = 8,
  parameter int HALF_BIT_US = 889
) (
  input wire logic MCLK_IN, // Clock
  input wire logic RST_N_IN, // Reset
  input wire logic [PIN_CNT-1:0] IR_PINS_IN, // Pins
  input wire logic [$clog2(PIN_CNT)-1:0] IR_INPUT_PIN_SELECT_IN, // Pin
  input wire logic EXT_EN_IN, // Ext
  input wire logic READY_IN, // Ready
  input wire logic [4:0] ADDR_OUT, // Address
  input wire logic [7:0] CMD_OUT, // Command
  input wire logic VALID_OUT, // Valid
  input wire logic ERR_OUT, // Error
  input wire logic BUSY_OUT // Busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Loose bound: every bit long and late still ends well inside it
  localparam int LIMIT = 400 * HALF_BIT_US;
  int busy_q;
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      busy_q <= 0;
    end else begin
      busy_q <= BUSY_OUT ? busy_q + 1 : 0;
    end
  end
  property p_hold; !VALID_OUT |-> $stable({ADDR_OUT, CMD_OUT}); endproperty
  a_hold: assert property (p_hold)
    else $error("code moved without valid");
  property p_ready; VALID_OUT |-> $past(READY_IN); endproperty
  a_ready: assert property (p_ready)
    else $error("valid without ready");
  property p_reset; $rose(RST_N_IN) |-> !VALID_OUT && ADDR_OUT == 5'h00;
  endproperty
  a_reset: assert property (p_reset)
    else $error("output not clear after reset");
  property p_len; busy_q <= LIMIT; endproperty
  a_len: assert property (p_len)
    else $error("frame too long");
  property p_start;
    $rose(BUSY_OUT) |-> !IR_PINS_IN[IR_INPUT_PIN_SELECT_IN];
  endproperty
  a_start: assert property (p_start)
    else $error("start not on selected pin");
  property p_quiet;
    IR_PINS_IN[IR_INPUT_PIN_SELECT_IN] [*6] |-> !$rose(BUSY_OUT);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("start without edge");
  property p_err; ERR_OUT |-> !BUSY_OUT ##1 !BUSY_OUT [*8]; endproperty
  a_err: assert property (p_err)
    else $error("busy after reject");
  property p_errpulse; ERR_OUT |=> !ERR_OUT; endproperty
  a_errpulse: assert property (p_errpulse)
    else $error("error not a pulse");
  c_valid: cover property (VALID_OUT);
  c_err: cover property (ERR_OUT);
  c_ext: cover property (VALID_OUT && CMD_OUT[6]);
endmodule // ir_rx_chk

bind biphase_ir_remote_receiver ir_rx_chk #(.PIN_CNT(PIN_CNT),
  .HALF_BIT_US(HALF_BIT_US)) chk_u (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN),
  .IR_PINS_IN(IR_PINS_IN), .IR_INPUT_PIN_SELECT_IN(IR_INPUT_PIN_SELECT_IN),
  .EXT_EN_IN(EXT_EN_IN), .READY_IN(READY_IN), .ADDR_OUT(ADDR_OUT),
  .CMD_OUT(CMD_OUT), .VALID_OUT(VALID_OUT), .ERR_OUT(ERR_OUT),
  .BUSY_OUT(BUSY_OUT));

// [tb/biphase_ir_remote_receiver_tb_top.sv]
module biphase_ir_remote_receiver_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HC = 120;
  logic mclk, rst_n, ext_en, ready, go, line, s_busy, valid, err, busy;
  logic [7:0] pins, cmd, vc;
  logic [4:0] addr, va;
  logic [2:0] sel;
  logic [13:0] word;
  int half, nv, ne, nbusy, n_fail, n_checks;
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Unselected pins carry the inverse, so a wrong pick cannot pass
  assign pins = {8{~line}} ^ (8'h01 << sel);
  ir_sender snd_u (.clk_in(mclk), .go_in(go), .word_in(word),
    .half_in(half), .line_out(line), .busy_out(s_busy));
  biphase_ir_remote_receiver #(.HALF_BIT_US(12)) dut_u (.MCLK_IN(mclk),
    .RST_N_IN(rst_n), .IR_PINS_IN(pins), .IR_INPUT_PIN_SELECT_IN(sel),
    .EXT_EN_IN(ext_en), .READY_IN(ready), .ADDR_OUT(addr), .CMD_OUT(cmd),
    .VALID_OUT(valid), .ERR_OUT(err), .BUSY_OUT(busy));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic frame(input logic [13:0] w, input int h);
    word <= w;
    half <= h;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    nv = 0;
    ne = 0;
    nbusy = 0;
    do begin
      @(negedge mclk);
      if (busy === 1'b1) nbusy++;
      if (valid === 1'b1) begin
        nv++;
        va = addr;
        vc = cmd;
      end
      if (err === 1'b1) ne++;
    end while (s_busy === 1'b1);
    repeat (400) @(posedge mclk);
  endtask
  task automatic code(input logic [13:0] w, input int h);
    frame(w, h);
    check(8'(nv), 8'h01);
    check({3'h0, va}, {3'h0, w[10:6]});
    check(vc, {w[11], ~w[12], w[5:0]});
    check(8'(ne), 8'h00);
    check(8'(nbusy == 26 * h), 8'h01);
  endtask
  task automatic t_fields();
    logic [13:0] w [3] = '{14'h3000, 14'h3FFF, 14'h3D6A};
    for (int i = 0; i < 3; i++) begin
      sel <= 3'(i * 3 + 1);
      code(w[i], HC);
    end
  endtask
  task automatic t_ext();
    ext_en <= 1'b1;
    code(14'h2CB3, HC);
    ext_en <= 1'b0;
    frame(14'h2CB3, HC);
    check(8'(ne), 8'h01);
    check(8'(nv), 8'h00);
  endtask
  task automatic t_timing();
    code(14'h3155, 130);
    frame(14'h3155, 40);
    check(8'(ne > 0), 8'h01);
    check(8'(nv), 8'h00);
  endtask
  task automatic t_fifo();
    int k;
    ready <= 1'b0;
    for (int i = 0; i < 18; i++) begin
      frame({3'b110, 5'(i), 6'(i)}, HC);
      check(8'(nv), 8'h00);
    end
    ready <= 1'b1;
    k = 0;
    repeat (60) begin
      @(negedge mclk);
      if (valid === 1'b1) begin
        check({3'h0, addr}, 8'(k));
        k++;
      end
    end
    check(8'(k), 8'h11);
  endtask
  task automatic test_done();
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    ext_en = 1'b0;
    ready = 1'b1;
    go = 1'b0;
    sel = 3'h1;
    word = 14'h0000;
    half = HC;
    n_fail = 0;
    n_checks = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (500) @(posedge mclk);
    t_fields();
    t_ext();
    t_timing();
    t_fifo();
    test_done();
  end
  // Some 25 frames of about 3800 clocks each
  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    test_done();
  end
endmodule // biphase_ir_remote_receiver_tb_top
